// ### hdl/gii_consts.vh
// Constants for the instrument-side IEEE-488 interface function set
`ifndef GII_CONSTS_VH
`define GII_CONSTS_VH

// ==========================================================================
// Timing
`define GII_CLK_NS 10
`define GII_T1_NS 2000
`define GII_T1_CYC 8'hC8
`define GII_CNT_W 8

// ==========================================================================
// Primary address
`define GII_ADDR_MAX 5'h1E
`define GII_ADDR_DEF 5'h1A

// ==========================================================================
// Address and command bytes, 7-bit, parity bit ignored
`define GII_LAG_BASE 7'h20
`define GII_TAG_BASE 7'h40
`define GII_UNL 7'h3F
`define GII_UNT 7'h5F
`define GII_GTL 7'h01
`define GII_SDC 7'h04
`define GII_GET 7'h08
`define GII_LLO 7'h11
`define GII_DCL 7'h14
`define GII_SPE 7'h18
`define GII_SPD 7'h19

// ==========================================================================
// Device-dependent execute character, upper and lower case
`define GII_EXEC_UC 8'h58
`define GII_EXEC_LC 8'h78

// ==========================================================================
// Acceptor handshake states
`define GII_AIDS 2'h0
`define GII_ANRS 2'h1
`define GII_ACDS 2'h2
`define GII_AWNS 2'h3

// Source handshake states
`define GII_SIDS 2'h0
`define GII_SGNS 2'h1
`define GII_SDYS 2'h2
`define GII_STRS 2'h3

// Remote/local states: bit 0 remote, bit 1 lockout
`define GII_LOCS 2'h0
`define GII_REMS 2'h1
`define GII_LWLS 2'h2
`define GII_RWLS 2'h3

`endif

// ### hdl/gii_device.v
// Instrument-side IEEE-488 interface: handshakes, addressing, poll, remote/local
`timescale 1ns/1ns
`default_nettype none
`include "gii_consts.vh"

// What this block does
// - As talker, send every byte with the full three-wire source handshake.
// - As acceptor, drive the full handshake on not-ready and not-accepted lines.
// - Drive data lines only while addressed to talk, never otherwise.
// - Basic talker with serial poll; own listen address ends talk state.
// - Accept device data bytes only while addressed to listen.
// - Basic listener; own talk address ends listen state.
// - Assert service request and report its cause in the poll status byte.
// - Full remote/local state machine driven by remote enable and messages.
// - No parallel poll; never drive a poll response on data lines.
// - Device clear reinitializes the device-dependent state.
// - Group trigger while listening starts a triggered reading.
// - No controller role: never assert attention, interface clear, remote enable.
// - Decode primary addresses only; ignore secondary address bytes.
// - Ignore addressed commands until own listen address has been received.
// - Primary address accepts 0 to 30; other values are rejected.
// - Primary address defaults to 26 when no stored address applies.
// - Working address kept apart from saved address; saved loads at power-up.
// - Clear on universal DCL and on SDC while listening; controller picks scope.
// - Device command with remote enable false flags error and is not acted on.
// - Trigger during a running triggered reading is dropped with overrun error.
module gii_device #(
  parameter [`GII_CNT_W-1:0] SETTLE_CYC = `GII_T1_CYC
) (
  input wire clock,
  input wire rst,
  // Bus lines in message-true polarity: 1 means asserted
  input wire atnIn,
  input wire renIn,
  input wire ifcIn,
  input wire eoiIn,
  input wire davIn,
  input wire nrfdIn,
  input wire ndacIn,
  input wire [7:0] dioIn,
  output wire [7:0] dioOut,
  output wire dioOe,
  output wire eoiOut,
  output wire eoiOe,
  output wire davOut,
  output wire davOe,
  output wire nrfdOut,
  output wire nrfdOe,
  output wire ndacOut,
  output wire ndacOe,
  output wire srqOut,
  output wire srqOe,
  // Address store
  input wire [4:0] nvAddrIn,
  input wire [4:0] addrIn,
  input wire addrWrite,
  input wire addrSave,
  output wire [4:0] workAddr,
  output wire [4:0] nvAddrOut,
  output wire nvWrite,
  output wire addrReject,
  // Talker data
  input wire [7:0] txData,
  input wire txEnd,
  input wire txValid,
  output wire txReady,
  // Listener data and events
  output wire [7:0] rxData,
  output wire rxEnd,
  output wire rxValid,
  output wire execStrobe,
  output wire noRemoteErr,
  output wire clearStrobe,
  input wire readingBusy,
  output wire trigStrobe,
  output wire trigOverrun,
  // Service request
  input wire svcReq,
  input wire [5:0] svcCause,
  output wire polledStrobe,
  // Front panel and status
  input wire localKey,
  output wire remote,
  output wire lockout,
  output wire listenAct,
  output wire talkAct
);

  // ========================================================================
  // Registers
  reg [1:0] ahState_ff;
  reg [1:0] shState_ff;
  reg [1:0] rlState_ff;
  reg [`GII_CNT_W-1:0] settleCnt_ff;
  reg [7:0] cap_ff;
  reg capAtn_ff;
  reg capEoi_ff;
  reg listen_ff;
  reg talk_ff;
  reg spMode_ff;
  reg spByte_ff;
  reg srqPend_ff;
  reg [5:0] cause_ff;
  reg [4:0] workAddr_ff;
  reg [4:0] savedAddr_ff;
  reg loadPend_ff;
  reg nvWrite_ff;
  reg addrReject_ff;
  reg [7:0] dioOut_ff;
  reg dioOe_ff;
  reg eoiOut_ff;
  reg davOut_ff;
  reg nrfdOut_ff;
  reg ndacOut_ff;
  reg srqOut_ff;
  reg txReady_ff;
  reg [7:0] rxData_ff;
  reg rxEnd_ff;
  reg rxValid_ff;
  reg execStrobe_ff;
  reg noRemoteErr_ff;
  reg clearStrobe_ff;
  reg trigStrobe_ff;
  reg trigOverrun_ff;
  reg polledStrobe_ff;

  // Open-collector lines other than data: enable equals asserted, so one flop feeds both; data lines have their own enable flop
  assign dioOut = dioOut_ff;
  assign dioOe = dioOe_ff;
  assign eoiOut = eoiOut_ff;
  assign eoiOe = eoiOut_ff;
  assign davOut = davOut_ff;
  assign davOe = davOut_ff;
  assign nrfdOut = nrfdOut_ff;
  assign nrfdOe = nrfdOut_ff;
  assign ndacOut = ndacOut_ff;
  assign ndacOe = ndacOut_ff;
  assign srqOut = srqOut_ff;
  assign srqOe = srqOut_ff;
  assign workAddr = workAddr_ff;
  assign nvAddrOut = savedAddr_ff;
  assign nvWrite = nvWrite_ff;
  assign addrReject = addrReject_ff;
  assign txReady = txReady_ff;
  assign rxData = rxData_ff;
  assign rxEnd = rxEnd_ff;
  assign rxValid = rxValid_ff;
  assign execStrobe = execStrobe_ff;
  assign noRemoteErr = noRemoteErr_ff;
  assign clearStrobe = clearStrobe_ff;
  assign trigStrobe = trigStrobe_ff;
  assign trigOverrun = trigOverrun_ff;
  assign polledStrobe = polledStrobe_ff;
  assign remote = rlState_ff[0];
  assign lockout = rlState_ff[1];
  assign listenAct = listen_ff;
  assign talkAct = talk_ff;

  function addrOk;
    input [4:0] a;
    begin
      addrOk = (a <= `GII_ADDR_MAX);
    end
  endfunction

  // ========================================================================
  // Decode of the byte held in the accept state
  wire [6:0] cmd = cap_ff[6:0];
  wire byteNow = (ahState_ff == `GII_ACDS);
  wire cmdNow = byteNow & capAtn_ff;
  wire isMla = cmdNow & (cmd == (`GII_LAG_BASE | {2'h0, workAddr_ff}));
  wire isMta = cmdNow & (cmd == (`GII_TAG_BASE | {2'h0, workAddr_ff}));
  // Secondary bytes (60h-7Fh) fall through every compare below
  wire isOta = cmdNow & (cmd[6:5] == 2'h2) & ~isMta & (cmd != `GII_UNT);
  wire addrCmd = cmdNow & listen_ff;
  wire isGtl = addrCmd & (cmd == `GII_GTL);
  wire isSdc = addrCmd & (cmd == `GII_SDC);
  wire isGet = addrCmd & (cmd == `GII_GET);
  wire isLlo = cmdNow & (cmd == `GII_LLO);
  wire isDcl = cmdNow & (cmd == `GII_DCL);
  wire dataNow = byteNow & ~capAtn_ff & listen_ff;
  wire shActive = talk_ff & ~atnIn & ~ifcIn;
  wire polledDone = (shState_ff == `GII_STRS) & ~ndacIn & spByte_ff;

  // ========================================================================
  // Acceptor handshake
  // Engaged under attention for commands, or as listener for data
  wire ahEngaged = (atnIn | (listen_ff & ~talk_ff)) & ~ifcIn;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ahState_ff <= `GII_AIDS;
      cap_ff <= 8'h00;
      capAtn_ff <= 1'b0;
      capEoi_ff <= 1'b0;
      nrfdOut_ff <= 1'b0;
      ndacOut_ff <= 1'b0;
    end else if (!ahEngaged) begin
      ahState_ff <= `GII_AIDS;
      nrfdOut_ff <= 1'b0;
      ndacOut_ff <= 1'b0;
    end else begin
      case (ahState_ff)
        `GII_AIDS: begin
          ahState_ff <= `GII_ANRS;
          nrfdOut_ff <= 1'b0;
          ndacOut_ff <= 1'b1;
        end
        `GII_ANRS: begin
          if (davIn) begin
            ahState_ff <= `GII_ACDS;
            cap_ff <= dioIn;
            capAtn_ff <= atnIn;
            capEoi_ff <= eoiIn;
            nrfdOut_ff <= 1'b1;
          end
        end
        `GII_ACDS: begin
          ahState_ff <= `GII_AWNS;
          ndacOut_ff <= 1'b0;
        end
        `GII_AWNS: begin
          if (!davIn) begin
            ahState_ff <= `GII_ANRS;
            ndacOut_ff <= 1'b1;
            nrfdOut_ff <= 1'b0;
          end
        end
        default: begin
          ahState_ff <= `GII_AIDS;
        end
      endcase
    end
  end

  // ========================================================================
  // Source handshake; data lines are driven from here and nowhere else
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      shState_ff <= `GII_SIDS;
      settleCnt_ff <= {`GII_CNT_W{1'b0}};
      dioOut_ff <= 8'h00;
      dioOe_ff <= 1'b0;
      eoiOut_ff <= 1'b0;
      davOut_ff <= 1'b0;
      spByte_ff <= 1'b0;
      txReady_ff <= 1'b0;
      polledStrobe_ff <= 1'b0;
    end else begin
      txReady_ff <= 1'b0;
      polledStrobe_ff <= 1'b0;
      if (!shActive) begin
        // Attention or loss of talk state releases every line at once
        shState_ff <= `GII_SIDS;
        dioOe_ff <= 1'b0;
        eoiOut_ff <= 1'b0;
        davOut_ff <= 1'b0;
      end else begin
        case (shState_ff)
          `GII_SIDS: begin
            shState_ff <= `GII_SGNS;
          end
          `GII_SGNS: begin
            if (spMode_ff) begin
              dioOut_ff <= {1'b0, srqPend_ff, cause_ff};
              eoiOut_ff <= 1'b0;
              spByte_ff <= 1'b1;
              dioOe_ff <= 1'b1;
              settleCnt_ff <= SETTLE_CYC;
              shState_ff <= `GII_SDYS;
            end else if (txValid) begin
              dioOut_ff <= txData;
              eoiOut_ff <= txEnd;
              spByte_ff <= 1'b0;
              txReady_ff <= 1'b1;
              dioOe_ff <= 1'b1;
              settleCnt_ff <= SETTLE_CYC;
              shState_ff <= `GII_SDYS;
            end
          end
          `GII_SDYS: begin
            // Data must settle before the valid strobe, and a listener be ready
            if (settleCnt_ff != {`GII_CNT_W{1'b0}}) begin
              settleCnt_ff <= settleCnt_ff - 1'b1;
            end else if (!nrfdIn) begin
              davOut_ff <= 1'b1;
              shState_ff <= `GII_STRS;
            end
          end
          `GII_STRS: begin
            if (!ndacIn) begin
              davOut_ff <= 1'b0;
              dioOe_ff <= 1'b0;
              eoiOut_ff <= 1'b0;
              polledStrobe_ff <= spByte_ff;
              shState_ff <= `GII_SGNS;
            end
          end
          default: begin
            shState_ff <= `GII_SIDS;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Addressing, commands, remote/local and device events
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      listen_ff <= 1'b0;
      talk_ff <= 1'b0;
      spMode_ff <= 1'b0;
      rlState_ff <= `GII_LOCS;
      rxData_ff <= 8'h00;
      rxEnd_ff <= 1'b0;
      rxValid_ff <= 1'b0;
      execStrobe_ff <= 1'b0;
      noRemoteErr_ff <= 1'b0;
      clearStrobe_ff <= 1'b0;
      trigStrobe_ff <= 1'b0;
      trigOverrun_ff <= 1'b0;
    end else begin
      rxValid_ff <= 1'b0;
      execStrobe_ff <= 1'b0;
      noRemoteErr_ff <= 1'b0;
      clearStrobe_ff <= isDcl | isSdc;
      trigStrobe_ff <= isGet & ~readingBusy;
      trigOverrun_ff <= isGet & readingBusy;
      if (ifcIn) begin
        listen_ff <= 1'b0;
        talk_ff <= 1'b0;
        spMode_ff <= 1'b0;
      end else begin
        if (isMla) begin
          listen_ff <= 1'b1;
          talk_ff <= 1'b0;
        end else if (isMta) begin
          talk_ff <= 1'b1;
          listen_ff <= 1'b0;
        end else if (cmdNow & (cmd == `GII_UNL)) begin
          listen_ff <= 1'b0;
        end else if (cmdNow & (cmd == `GII_UNT)) begin
          talk_ff <= 1'b0;
        end else if (isOta) begin
          talk_ff <= 1'b0;
        end
        if (cmdNow & (cmd == `GII_SPE)) begin
          spMode_ff <= 1'b1;
        end else if (cmdNow & (cmd == `GII_SPD)) begin
          spMode_ff <= 1'b0;
        end
      end
      if (dataNow) begin
        if (renIn) begin
          rxData_ff <= cap_ff;
          rxEnd_ff <= capEoi_ff;
          rxValid_ff <= 1'b1;
          execStrobe_ff <= (cap_ff == `GII_EXEC_UC) | (cap_ff == `GII_EXEC_LC);
        end else begin
          noRemoteErr_ff <= 1'b1;
        end
      end
      // Remote enable false overrides every other transition
      if (!renIn) begin
        rlState_ff <= `GII_LOCS;
      end else begin
        case (rlState_ff)
          `GII_LOCS: begin
            if (isLlo) begin
              rlState_ff <= `GII_LWLS;
            end else if (isMla) begin
              rlState_ff <= `GII_REMS;
            end
          end
          `GII_REMS: begin
            if (isLlo) begin
              rlState_ff <= `GII_RWLS;
            end else if (isGtl | localKey) begin
              rlState_ff <= `GII_LOCS;
            end
          end
          `GII_LWLS: begin
            if (isMla) begin
              rlState_ff <= `GII_RWLS;
            end
          end
          `GII_RWLS: begin
            if (isGtl) begin
              rlState_ff <= `GII_LWLS;
            end
          end
          default: begin
            rlState_ff <= `GII_LOCS;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Service request; a new request in the poll cycle wins over the clear
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      srqPend_ff <= 1'b0;
      cause_ff <= 6'h00;
      srqOut_ff <= 1'b0;
    end else begin
      if (svcReq) begin
        srqPend_ff <= 1'b1;
        cause_ff <= svcCause;
        srqOut_ff <= 1'b1;
      end else if (polledDone) begin
        srqPend_ff <= 1'b0;
        srqOut_ff <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Primary address: the saved value is caught once, the cycle after reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      workAddr_ff <= `GII_ADDR_DEF;
      savedAddr_ff <= `GII_ADDR_DEF;
      loadPend_ff <= 1'b1;
      nvWrite_ff <= 1'b0;
      addrReject_ff <= 1'b0;
    end else begin
      nvWrite_ff <= 1'b0;
      addrReject_ff <= 1'b0;
      if (loadPend_ff) begin
        loadPend_ff <= 1'b0;
        if (addrOk(nvAddrIn)) begin
          workAddr_ff <= nvAddrIn;
          savedAddr_ff <= nvAddrIn;
        end
      end else if (addrWrite) begin
        if (addrOk(addrIn)) begin
          workAddr_ff <= addrIn;
        end else begin
          addrReject_ff <= 1'b1;
        end
      end else if (addrSave) begin
        savedAddr_ff <= workAddr_ff;
        nvWrite_ff <= 1'b1;
      end
    end
  end

endmodule // gii_device

`default_nettype wire

// ### verif/gii_device_chk.sv
// Port-level assertion checker for the instrument-side bus interface
`timescale 1ns/1ns
`default_nettype none
`include "gii_consts.vh"
// ========================================
// Checker
module gii_device_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic atnIn,
  input wire logic davIn,
  input wire logic nrfdIn,
  input wire logic ndacIn,
  input wire logic dioOe,
  input wire logic [7:0] dioOut,
  input wire logic davOut,
  input wire logic nrfdOut,
  input wire logic ndacOut,
  input wire logic [4:0] addrIn,
  input wire logic addrWrite,
  input wire logic addrSave,
  input wire logic [4:0] workAddr,
  input wire logic [4:0] nvAddrOut,
  input wire logic nvWrite,
  input wire logic addrReject,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic execStrobe,
  input wire logic noRemoteErr,
  input wire logic trigStrobe,
  input wire logic trigOverrun,
  input wire logic listenAct,
  input wire logic talkAct
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_dio_talk_only: assert property (dioOe |-> $past(talkAct) && !$past(atnIn))
    else $error("data lines driven outside talk");
  chk_dav_wait_ready: assert property ($rose(davOut) |-> !$past(nrfdIn))
    else $error("dav raised while not ready");
  chk_dav_data_held: assert property (davOut |-> dioOe && $stable(dioOut))
    else $error("data moved under dav");
  chk_dav_release: assert property (davOut && !ndacIn |=> !davOut)
    else $error("dav held after accept");
  chk_accept_walk: assert property ($rose(davIn) && ndacOut && !nrfdOut |=> nrfdOut ##1 !ndacOut)
    else $error("acceptor walk broken");
  chk_accept_done: assert property (!davIn && nrfdOut && !ndacOut |=> ndacOut && !nrfdOut)
    else $error("acceptor did not rearm");
  chk_addr_reject: assert property (addrWrite && addrIn > `GII_ADDR_MAX |=> addrReject && $stable(workAddr))
    else $error("bad address taken");
  chk_addr_take: assert property (addrWrite && addrIn <= `GII_ADDR_MAX |=> workAddr == $past(addrIn))
    else $error("good address lost");
  chk_save_copy: assert property (addrSave |=> nvWrite && nvAddrOut == $past(workAddr))
    else $error("saved address wrong");
  chk_roles_apart: assert property (!(talkAct && listenAct))
    else $error("talk and listen together");
  chk_rx_listen: assert property (rxValid |-> listenAct && !noRemoteErr)
    else $error("byte passed while not listening");
  chk_exec_char: assert property (execStrobe |-> rxValid && (rxData == `GII_EXEC_UC || rxData == `GII_EXEC_LC))
    else $error("execute on wrong byte");
  chk_trig_drop: assert property (trigOverrun |-> !trigStrobe)
    else $error("overrun trigger acted on");
endmodule // gii_device_chk
// ========================================
// Attachment
bind gii_device gii_device_chk gii_device_chk_i (.clock(clock), .rst(rst), .atnIn(atnIn), .davIn(davIn),
  .nrfdIn(nrfdIn), .ndacIn(ndacIn), .dioOe(dioOe), .dioOut(dioOut), .davOut(davOut), .nrfdOut(nrfdOut),
  .ndacOut(ndacOut), .addrIn(addrIn), .addrWrite(addrWrite), .addrSave(addrSave), .workAddr(workAddr),
  .nvAddrOut(nvAddrOut), .nvWrite(nvWrite), .addrReject(addrReject), .rxData(rxData), .rxValid(rxValid),
  .execStrobe(execStrobe), .noRemoteErr(noRemoteErr), .trigStrobe(trigStrobe), .trigOverrun(trigOverrun),
  .listenAct(listenAct), .talkAct(talkAct));
`default_nettype wire

// ### verif/gii_ctl_model.sv
// Bus controller model: sources commands and data, listens to the device
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Controller
module gii_ctl_model (
  input wire logic clock,
  input wire logic davBus,
  input wire logic nrfdBus,
  input wire logic ndacBus,
  input wire logic eoiBus,
  input wire logic [7:0] dioBus,
  output var logic atn,
  output var logic ren,
  output var logic ifc,
  output var logic eoi,
  output var logic dav,
  output var logic nrfd,
  output var logic ndac,
  output var logic [7:0] dio
);
  initial begin
    {atn, ren, ifc, eoi, dav, nrfd, ndac} = 7'h00;
    dio = 8'h00;
  end
  task automatic setRen(input logic v);
    ren = v;
    repeat (2) @(negedge clock);
  endtask
  // Ends holding not-ready so a talker cannot send into an empty bus
  task automatic send(input logic a, input logic [7:0] b);
    nrfd = 1'b0;
    ndac = 1'b0;
    atn = a;
    dio = b;
    @(negedge clock);
    for (int k = 0; k < 600 && nrfdBus !== 1'b0; k++) @(negedge clock);
    @(negedge clock);
    dav = 1'b1;
    for (int k = 0; k < 600 && ndacBus !== 1'b0; k++) @(negedge clock);
    dav = 1'b0;
    dio = 8'h00;
    nrfd = 1'b1;
    ndac = 1'b1;
    repeat (3) @(negedge clock);
    atn = 1'b0;
    @(negedge clock);
  endtask
  // Hold stretches the accept to act as a slow listener
  task automatic recv(output logic [7:0] b, output logic e, input int hold);
    ndac = 1'b1;
    nrfd = 1'b0;
    for (int k = 0; k < 600 && davBus !== 1'b1; k++) @(negedge clock);
    b = dioBus;
    e = eoiBus;
    nrfd = 1'b1;
    repeat (hold + 1) @(negedge clock);
    ndac = 1'b0;
    for (int k = 0; k < 600 && davBus !== 1'b0; k++) @(negedge clock);
    ndac = 1'b1;
  endtask
endmodule // gii_ctl_model
`default_nettype wire

// ### verif/gii_device_bench.sv
// Self-checking bench for the instrument-side bus interface
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Harness
module gii_device_bench;
  logic clock, rst, addrWrite, addrSave, txEnd, txValid, readingBusy, svcReq, localKey;
  logic [4:0] nvAddrIn, addrIn, pa;
  logic [5:0] svcCause;
  logic [7:0] txData;
  wire logic atnIn, renIn, ifcIn, ctlEoi, ctlDav, ctlNrfd, ctlNdac, dioOe, eoiOut, eoiOe, davOut, davOe;
  wire logic nrfdOut, nrfdOe, ndacOut, ndacOe, srqOut, srqOe, nvWrite, addrReject, txReady, rxEnd, rxValid;
  wire logic execStrobe, noRemoteErr, clearStrobe, trigStrobe, trigOverrun, polledStrobe, remote, lockout;
  wire logic listenAct, talkAct;
  wire logic [4:0] workAddr, nvAddrOut;
  wire logic [7:0] ctlDio, dioOut, rxData;
  int miscompares = 0;
  int cmp_count = 0;
  int cRx = 0, cExec = 0, cClr = 0, cTrig = 0, cOvr = 0, cNre = 0, cPoll = 0;
  // Open-collector lines: any party asserting wins
  wire logic eoiIn = ctlEoi | (eoiOe & eoiOut);
  wire logic davIn = ctlDav | (davOe & davOut);
  wire logic nrfdIn = ctlNrfd | (nrfdOe & nrfdOut);
  wire logic ndacIn = ctlNdac | (ndacOe & ndacOut);
  wire logic [7:0] dioIn = ctlDio | (dioOe ? dioOut : 8'h00);
  gii_device #(.SETTLE_CYC(8'h02)) gii_device_i (.clock(clock), .rst(rst), .atnIn(atnIn), .renIn(renIn),
    .ifcIn(ifcIn), .eoiIn(eoiIn), .davIn(davIn), .nrfdIn(nrfdIn), .ndacIn(ndacIn), .dioIn(dioIn),
    .dioOut(dioOut), .dioOe(dioOe), .eoiOut(eoiOut), .eoiOe(eoiOe), .davOut(davOut), .davOe(davOe),
    .nrfdOut(nrfdOut), .nrfdOe(nrfdOe), .ndacOut(ndacOut), .ndacOe(ndacOe), .srqOut(srqOut), .srqOe(srqOe),
    .nvAddrIn(nvAddrIn), .addrIn(addrIn), .addrWrite(addrWrite), .addrSave(addrSave), .workAddr(workAddr),
    .nvAddrOut(nvAddrOut), .nvWrite(nvWrite), .addrReject(addrReject), .txData(txData), .txEnd(txEnd),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxEnd(rxEnd), .rxValid(rxValid),
    .execStrobe(execStrobe), .noRemoteErr(noRemoteErr), .clearStrobe(clearStrobe), .readingBusy(readingBusy),
    .trigStrobe(trigStrobe), .trigOverrun(trigOverrun), .svcReq(svcReq), .svcCause(svcCause),
    .polledStrobe(polledStrobe), .localKey(localKey), .remote(remote), .lockout(lockout),
    .listenAct(listenAct), .talkAct(talkAct));
  gii_ctl_model gii_ctl_model_i (.clock(clock), .davBus(davIn), .nrfdBus(nrfdIn), .ndacBus(ndacIn),
    .eoiBus(eoiIn), .dioBus(dioIn), .atn(atnIn), .ren(renIn), .ifc(ifcIn), .eoi(ctlEoi), .dav(ctlDav),
    .nrfd(ctlNrfd), .ndac(ctlNdac), .dio(ctlDio));
  always #5 clock = ~clock;
  // Strobes last one cycle, so they are tallied here rather than polled
  always @(posedge clock) begin
    cRx += int'(rxValid === 1'b1);
    cExec += int'(execStrobe === 1'b1);
    cClr += int'(clearStrobe === 1'b1);
    cTrig += int'(trigStrobe === 1'b1);
    cOvr += int'(trigOverrun === 1'b1);
    cNre += int'(noRemoteErr === 1'b1);
    cPoll += int'(polledStrobe === 1'b1);
  end
  // ========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic cmd(input logic [7:0] b);
    gii_ctl_model_i.send(1'b1, b);
  endtask
  task automatic dat(input logic [7:0] b);
    gii_ctl_model_i.send(1'b0, b);
  endtask
  task automatic wr(input logic [4:0] a, input logic rej, input logic [4:0] exp);
    addrIn = a;
    addrWrite = 1'b1;
    tick(1);
    addrWrite = 1'b0;
    chk(addrReject, rej, "address reject");
    chk(workAddr, exp, "working address");
  endtask
  task automatic xfer(input logic [7:0] b, input logic e, input int hold);
    logic [7:0] g;
    logic ge;
    txData = b;
    txEnd = e;
    txValid = 1'b1;
    fork
      begin
        for (int k = 0; k < 600 && txReady !== 1'b1; k++) @(negedge clock);
        txValid = 1'b0;
      end
      gii_ctl_model_i.recv(g, ge, hold);
    join
    chk(g, b, "talker byte");
    chk(ge, e, "end flag");
  endtask
  // ========================================
  // Scenarios
  task automatic t_addr;
    chk(workAddr, 5'h1A, "default address");
    wr(5'h1F, 1'b1, 5'h1A);
    wr(5'h00, 1'b0, 5'h00);
    wr(5'h1E, 1'b0, 5'h1E);
    addrSave = 1'b1;
    tick(1);
    addrSave = 1'b0;
    chk(nvAddrOut, 5'h1E, "saved address");
    nvAddrIn = 5'h03;
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(2);
    chk(workAddr, 5'h03, "power-up address");
    pa = 5'h03;
  endtask
  task automatic t_listen;
    int r0;
    r0 = cRx;
    gii_ctl_model_i.setRen(1'b1);
    dat({3'h1, pa});
    chk(listenAct, 1'b0, "address as data");
    cmd({3'h1, pa});
    chk(listenAct, 1'b1, "listen address");
    chk(remote, 1'b1, "remote");
    dat(8'h41);
    dat(8'h58);
    chk(cRx, r0 + 2, "listener bytes");
    chk(cExec, 1, "execute character");
    chk({rxEnd, rxData}, 9'h058, "listener byte");
    cmd({3'h3, pa});
    chk(listenAct, 1'b1, "secondary byte");
    cmd(8'h3F);
    chk(listenAct, 1'b0, "unlisten");
    dat(8'h41);
    chk(cRx, r0 + 2, "unaddressed data");
    localKey = 1'b1;
    tick(1);
    localKey = 1'b0;
    chk(remote, 1'b0, "local key");
  endtask
  task automatic t_cmds;
    cmd(8'h08);
    cmd(8'h04);
    chk(cTrig + cClr, 0, "unaddressed commands");
    cmd({3'h1, pa});
    cmd(8'h08);
    chk(cTrig, 1, "trigger");
    readingBusy = 1'b1;
    cmd(8'h08);
    chk(cOvr, 1, "overrun");
    chk(cTrig, 1, "overrun dropped");
    readingBusy = 1'b0;
    cmd(8'h04);
    chk(cClr, 1, "selected clear");
    cmd(8'h01);
    chk(remote, 1'b0, "go to local");
    cmd(8'h11);
    chk(lockout, 1'b1, "lockout");
    cmd({3'h2, pa});
    chk({listenAct, talkAct}, 2'h1, "talk ends listen");
    cmd({3'h1, pa});
    chk({listenAct, talkAct}, 2'h2, "listen ends talk");
    cmd(8'h3F);
    cmd(8'h14);
    chk(cClr, 2, "universal clear");
    gii_ctl_model_i.setRen(1'b0);
    chk({remote, lockout}, 2'h0, "remote enable false");
    cmd({3'h1, pa});
    dat(8'h41);
    chk(cNre, 1, "no remote error");
    chk(cRx, 2, "byte withheld");
    cmd(8'h3F);
    gii_ctl_model_i.setRen(1'b1);
  endtask
  task automatic t_talk;
    txValid = 1'b1;
    tick(4);
    txValid = 1'b0;
    chk(dioOe, 1'b0, "unaddressed talker");
    cmd({3'h2, pa});
    chk(talkAct, 1'b1, "talk address");
    xfer(8'hA5, 1'b0, 0);
    xfer(8'h3C, 1'b1, 5);
    cmd(8'h5F);
    chk(talkAct, 1'b0, "untalk");
  endtask
  task automatic t_poll;
    logic [7:0] g;
    logic ge;
    svcCause = 6'h2A;
    svcReq = 1'b1;
    tick(1);
    svcReq = 1'b0;
    chk(srqOut, 1'b1, "service request");
    cmd(8'h18);
    cmd({3'h2, pa});
    gii_ctl_model_i.recv(g, ge, 0);
    chk(g, 8'h6A, "status byte");
    tick(2);
    chk({srqOut, cPoll[0]}, 2'h1, "request cleared");
    cmd(8'h19);
    gii_ctl_model_i.ifc = 1'b1;
    tick(1);
    gii_ctl_model_i.ifc = 1'b0;
    chk(talkAct, 1'b0, "interface clear");
    cmd(8'h5F);
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    {clock, rst, addrWrite, addrSave, txEnd, txValid, readingBusy, svcReq, localKey} = 9'h080;
    {nvAddrIn, addrIn, pa} = 15'h7C00;
    svcCause = 6'h00;
    txData = 8'h00;
    tick(3);
    rst = 1'b0;
    tick(2);
    t_addr();
    t_listen();
    t_cmds();
    t_talk();
    t_poll();
    conclude();
  end
endmodule // gii_device_bench
`default_nettype wire
